// ===== hw/cgcd_pkg.sv
// Constants shared by the counter gating and command decoder
package cgcd_pkg;
  localparam int          NCNT       = 5;
  localparam int          CNT_W      = 16;
  localparam logic [15:0] MODE_RST   = 16'h0800;
  localparam logic [15:0] TC_DOWN    = 16'h0001;
  localparam logic [15:0] TC_UP      = 16'hffff;
  // Counter mode word fields
  localparam int          CM_UP      = 3;
  localparam int          CM_REPEAT  = 5;
  localparam int          CM_RETRIG  = 7;
  localparam int          CM_SRC_LO  = 8;
  localparam int          CM_POL     = 12;
  localparam int          CM_GATE_LO = 13;
  // Gating field codes
  localparam logic [2:0]  G_NONE     = 3'h0;
  localparam logic [2:0]  G_LOWTC    = 3'h1;
  localparam logic [2:0]  G_UPPER    = 3'h2;
  localparam logic [2:0]  G_LOWER    = 3'h3;
  localparam logic [2:0]  G_HIGH     = 3'h4;
  localparam logic [2:0]  G_LOW      = 3'h5;
  localparam logic [2:0]  G_FALL     = 3'h7;
  // Command groups in the upper three command bits
  localparam logic [2:0]  OP_DPTR    = 3'h0;
  localparam logic [2:0]  OP_ARM     = 3'h1;
  localparam logic [2:0]  OP_LOAD    = 3'h2;
  localparam logic [2:0]  OP_LDARM   = 3'h3;
  localparam logic [2:0]  OP_DSAVE   = 3'h4;
  localparam logic [2:0]  OP_SAVE    = 3'h5;
  localparam logic [2:0]  OP_DISARM  = 3'h6;
  localparam logic [2:0]  OP_MISC    = 3'h7;
  localparam logic [1:0]  SUB_CLR    = 2'h0;
  localparam logic [1:0]  SUB_SET    = 2'h1;
  localparam logic [1:0]  SUB_STEP   = 2'h2;
  // Dedicated full codes
  localparam logic [7:0]  C_SEQ_OFF  = 8'he8;
  localparam logic [7:0]  C_FREQUENCY_OUTPUT_OFF = 8'hee;
  localparam logic [7:0]  C_WIDE_ON  = 8'hef;
  localparam logic [7:0]  C_SEQ_ON   = 8'he0;
  localparam logic [7:0]  C_FREQUENCY_OUTPUT_ON  = 8'he6;
  localparam logic [7:0]  C_WIDE_OFF = 8'he7;
  localparam logic [7:0]  C_PF_ON    = 8'hf8;
  localparam logic [7:0]  C_PF_OFF   = 8'hf9;
  localparam logic [7:0]  C_MRESET   = 8'hff;
endpackage

// ===== hw/cgcd_edge.sv
// Edge detector with selectable polarity
`timescale 1ns/10ps
module cgcd_edge (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Level in, pulse out
  input  wire logic sig,
  input  wire logic fall,
  output logic      edge_p
);
  logic prev_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sig;
    end
  end

  assign edge_p = fall ? (prev_q & ~sig) : (~prev_q & sig);
endmodule

// ===== hw/cgcd_counter.sv
// One counter: count, reload, retrigger, arm and toggle state
`timescale 1ns/10ps
module cgcd_counter (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Gating and source
  input  wire logic        src_edge,
  input  wire logic        level_ok,
  input  wire logic        edge_mode,
  input  wire logic        gate_edge,
  input  wire logic        retrig,
  input  wire logic        reload_hold,
  input  wire logic        up,
  input  wire logic        repeat_bit,
  // Commands
  input  wire logic        arm,
  input  wire logic        load,
  input  wire logic        ldarm,
  input  wire logic        disarm,
  input  wire logic        save,
  input  wire logic        step,
  input  wire logic        set_tog,
  input  wire logic        clr_tog,
  input  wire logic        mreset,
  input  wire logic        load_wr,
  input  wire logic [15:0] load_wdata,
  // State
  output logic      [15:0] cnt_q,
  output logic      [15:0] hold_q,
  output logic      [15:0] load_q,
  output logic             armed_q,
  output logic             tc_q,
  output logic             tog_q,
  output logic             pend_q,
  output logic             dpend_q,
  output logic             qual
);
  logic [15:0] cnt_d;
  logic [15:0] reload_val;
  logic        tc_d;
  logic        pend_d;
  logic        run_q;
  logic        gate_on;
  logic        adv;
  logic        ld_any;
  logic        at_tc;
  logic        tc_ev;
  logic        leave_tc;

  assign gate_on    = edge_mode ? run_q : level_ok;
  assign qual       = src_edge & ((armed_q & gate_on) | tc_q);
  assign adv        = qual | step;
  assign ld_any     = load | ldarm;
  assign reload_val = reload_hold ? hold_q : load_q;
  assign at_tc      = up ? (cnt_q == cgcd_pkg::TC_UP)
                         : (cnt_q == cgcd_pkg::TC_DOWN);
  assign tc_ev      = adv & ~pend_q & at_tc;
  assign leave_tc   = tc_q & (adv | ld_any);

  always_comb begin
    cnt_d  = cnt_q;
    tc_d   = tc_q;
    pend_d = pend_q;
    if (pend_q && (adv || ld_any)) begin
      cnt_d  = load_q;
      pend_d = 1'b0;
      tc_d   = 1'b0;
    end else if (ld_any) begin
      cnt_d = reload_val;
      tc_d  = 1'b0;
    end else if (adv) begin
      if (at_tc) begin
        cnt_d = reload_val;
        tc_d  = 1'b1;
      end else begin
        cnt_d = up ? 16'(cnt_q + 16'h0001) : 16'(cnt_q - 16'h0001);
        tc_d  = 1'b0;
      end
    end
    if (retrig) begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= 16'h0000;
      hold_q  <= 16'h0000;
      load_q  <= 16'h0000;
      armed_q <= 1'b0;
      tc_q    <= 1'b0;
      tog_q   <= 1'b0;
      pend_q  <= 1'b0;
      dpend_q <= 1'b0;
      run_q   <= 1'b0;
    end else if (mreset) begin
      armed_q <= 1'b0;
      tc_q    <= 1'b0;
      pend_q  <= 1'b0;
      dpend_q <= 1'b0;
      run_q   <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tc_q   <= tc_d;
      pend_q <= pend_d;
      if (retrig || save) begin
        hold_q <= cnt_q;
      end
      if (load_wr) begin
        load_q <= load_wdata;
      end
      if (arm || ldarm) begin
        armed_q <= 1'b1;
      end else if ((disarm || dpend_q) && leave_tc) begin
        armed_q <= 1'b0;
      end else if (disarm && !tc_q) begin
        armed_q <= 1'b0;
      end else if (tc_ev && !repeat_bit) begin
        armed_q <= 1'b0;
      end
      if (ldarm || leave_tc) begin
        dpend_q <= 1'b0;
      end else if (disarm && tc_q) begin
        dpend_q <= 1'b1;
      end
      if (edge_mode && gate_edge) begin
        run_q <= 1'b1;
      end else if (tc_ev) begin
        run_q <= 1'b0;
      end
      if (set_tog) begin
        tog_q <= 1'b1;
      end else if (clr_tog) begin
        tog_q <= 1'b0;
      end else if (leave_tc) begin
        tog_q <= ~tog_q;
      end
    end
  end
endmodule

// ===== hw/cgcd_top.sv
// Counter gating, source selection and host command decoder
`timescale 1ns/10ps
module cgcd_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Host port
  input  wire logic        cmd_wr,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        mode_wr,
  input  wire logic        load_wr,
  input  wire logic [2:0]  cnt_sel,
  input  wire logic [15:0] wdata,
  // Pins
  input  wire logic [4:0]  freq_in,
  input  wire logic [4:0]  source_pin,
  input  wire logic [4:0]  own_gate_pin,
  // Counter state
  output logic      [4:0]  terminal_count,
  output logic      [4:0]  counter_output_pin,
  output logic      [4:0]  armed,
  // Read data
  output logic      [15:0] mode_rdata,
  output logic      [15:0] hold_rdata,
  // Master bits
  output logic      [4:0]  data_ptr,
  output logic             sequencing_disable,
  output logic             freq_out_gate_off,
  output logic             wide_bus,
  output logic             write_prefetch
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic [1:0]  rst_sync_q;
  logic        rst_s_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_s_n = rst_sync_q[1];

  // ------------------------------------------------------------
  // Command register
  // ------------------------------------------------------------
  logic [7:0]  cmd_q;
  logic        cmd_vld_q;

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      cmd_q     <= 8'h00;
      cmd_vld_q <= 1'b0;
    end else begin
      cmd_vld_q <= cmd_wr;
      if (cmd_wr) begin
        cmd_q <= cmd_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  logic [2:0]  op;
  logic [1:0]  sub;
  logic [2:0]  num;
  logic [4:0]  mask;
  logic [4:0]  n_hot;
  logic        misc;
  logic        dp_ld;
  logic        mreset;
  logic [4:0]  arm_v;
  logic [4:0]  load_v;
  logic [4:0]  ldarm_v;
  logic [4:0]  disarm_v;
  logic [4:0]  save_v;
  logic [4:0]  set_v;
  logic [4:0]  clr_v;
  logic [4:0]  step_v;

  assign op       = cmd_q[7:5];
  assign sub      = cmd_q[4:3];
  assign num      = cmd_q[2:0];
  assign mask     = cmd_q[4:0];
  assign misc     = cmd_vld_q && (op == cgcd_pkg::OP_MISC);
  assign dp_ld    = cmd_vld_q && (op == cgcd_pkg::OP_DPTR);
  assign mreset   = cmd_vld_q && (cmd_q == cgcd_pkg::C_MRESET);
  assign arm_v    = (cmd_vld_q && op == cgcd_pkg::OP_ARM) ? mask
                    : 5'h00;
  assign load_v   = (cmd_vld_q && op == cgcd_pkg::OP_LOAD) ? mask
                    : 5'h00;
  assign ldarm_v  = (cmd_vld_q && op == cgcd_pkg::OP_LDARM) ? mask
                    : 5'h00;
  assign disarm_v = (cmd_vld_q && (op == cgcd_pkg::OP_DISARM
                    || op == cgcd_pkg::OP_DSAVE)) ? mask : 5'h00;
  assign save_v   = (cmd_vld_q && (op == cgcd_pkg::OP_SAVE
                    || op == cgcd_pkg::OP_DSAVE)) ? mask : 5'h00;
  assign set_v    = (misc && sub == cgcd_pkg::SUB_SET) ? n_hot
                    : 5'h00;
  assign clr_v    = (misc && sub == cgcd_pkg::SUB_CLR) ? n_hot
                    : 5'h00;
  assign step_v   = (misc && sub == cgcd_pkg::SUB_STEP) ? n_hot
                    : 5'h00;

  // ------------------------------------------------------------
  // Master bits and data pointer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      data_ptr           <= 5'h00;
      sequencing_disable <= 1'b0;
      freq_out_gate_off  <= 1'b0;
      wide_bus           <= 1'b0;
      write_prefetch     <= 1'b0;
    end else if (mreset) begin
      data_ptr           <= 5'h00;
      sequencing_disable <= 1'b0;
      freq_out_gate_off  <= 1'b0;
      wide_bus           <= 1'b0;
      write_prefetch     <= 1'b0;
    end else if (dp_ld) begin
      data_ptr <= mask;
    end else if (cmd_vld_q) begin
      case (cmd_q)
        cgcd_pkg::C_SEQ_OFF:  sequencing_disable <= 1'b1;
        cgcd_pkg::C_SEQ_ON:   sequencing_disable <= 1'b0;
        cgcd_pkg::C_FREQUENCY_OUTPUT_OFF: freq_out_gate_off  <= 1'b1;
        cgcd_pkg::C_FREQUENCY_OUTPUT_ON:  freq_out_gate_off  <= 1'b0;
        cgcd_pkg::C_WIDE_ON:  wide_bus           <= 1'b1;
        cgcd_pkg::C_WIDE_OFF: wide_bus           <= 1'b0;
        cgcd_pkg::C_PF_ON:    write_prefetch     <= 1'b1;
        cgcd_pkg::C_PF_OFF:   write_prefetch     <= 1'b0;
        default:              write_prefetch     <= write_prefetch;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Mode words
  // ------------------------------------------------------------
  logic [15:0] mode_q [5];

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      for (int k = 0; k < cgcd_pkg::NCNT; k++) begin
        mode_q[k] <= cgcd_pkg::MODE_RST;
      end
    end else begin
      for (int k = 0; k < cgcd_pkg::NCNT; k++) begin
        if (mreset) begin
          mode_q[k] <= cgcd_pkg::MODE_RST;
        end else if (mode_wr && cnt_sel == 3'(k + 1)) begin
          mode_q[k] <= wdata;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Per-counter gating, source and counter
  // ------------------------------------------------------------
  logic [15:0] cnt_w  [5];
  logic [15:0] hold_w [5];
  logic [15:0] load_w [5];
  logic [4:0]  pend_w;
  logic [4:0]  dpend_w;
  logic [4:0]  qual_w;
  logic [4:0]  sedge_w;
  logic [4:0]  retrig_w;

  genvar i;
  generate
    for (i = 0; i < cgcd_pkg::NCNT; i++) begin : g_cnt
      localparam int LO = (i + 4) % 5;
      localparam int UP = (i + 1) % 5;
      logic [2:0]  gf;
      logic [15:0] src_vec;
      logic        gsig;
      logic        gedge;
      logic        sbit;

      assign n_hot[i] = (num == 3'(i + 1));
      assign gf       = mode_q[i][cgcd_pkg::CM_GATE_LO +: 3];
      assign gsig     = (gf == cgcd_pkg::G_LOWTC) ? terminal_count[LO]
                      : (gf == cgcd_pkg::G_UPPER) ? own_gate_pin[UP]
                      : (gf == cgcd_pkg::G_LOWER) ? own_gate_pin[LO]
                      : (gf == cgcd_pkg::G_LOW || gf == cgcd_pkg::G_FALL)
                        ? ~own_gate_pin[i]
                      : own_gate_pin[i];
      assign src_vec  = {own_gate_pin[4:2], freq_in, own_gate_pin[1:0],
                         source_pin, terminal_count[LO]};
      assign sbit     = src_vec[mode_q[i][cgcd_pkg::CM_SRC_LO +: 4]];
      assign retrig_w[i] = (gf != cgcd_pkg::G_NONE)
                         & mode_q[i][cgcd_pkg::CM_RETRIG] & gedge;

      cgcd_edge u_src (
        .mclk   (mclk),
        .rst_n  (rst_s_n),
        .sig    (sbit),
        .fall   (mode_q[i][cgcd_pkg::CM_POL]),
        .edge_p (sedge_w[i])
      );

      cgcd_edge u_gate (
        .mclk   (mclk),
        .rst_n  (rst_s_n),
        .sig    (gsig),
        .fall   (1'b0),
        .edge_p (gedge)
      );

      cgcd_counter u_cnt (
        .mclk        (mclk),
        .rst_n       (rst_s_n),
        .src_edge    (sedge_w[i]),
        .level_ok    ((gf == cgcd_pkg::G_NONE) | gsig),
        .edge_mode   (gf[2] & gf[1]),
        .gate_edge   (gedge),
        .retrig      (retrig_w[i]),
        .reload_hold ((gf == cgcd_pkg::G_NONE)
                      & mode_q[i][cgcd_pkg::CM_RETRIG]
                      & own_gate_pin[i]),
        .up          (mode_q[i][cgcd_pkg::CM_UP]),
        .repeat_bit  (mode_q[i][cgcd_pkg::CM_REPEAT]),
        .arm         (arm_v[i]),
        .load        (load_v[i]),
        .ldarm       (ldarm_v[i]),
        .disarm      (disarm_v[i]),
        .save        (save_v[i]),
        .step        (step_v[i]),
        .set_tog     (set_v[i]),
        .clr_tog     (clr_v[i]),
        .mreset      (mreset),
        .load_wr     (load_wr && cnt_sel == 3'(i + 1)),
        .load_wdata  (wdata),
        .cnt_q       (cnt_w[i]),
        .hold_q      (hold_w[i]),
        .load_q      (load_w[i]),
        .armed_q     (armed[i]),
        .tc_q        (terminal_count[i]),
        .tog_q       (counter_output_pin[i]),
        .pend_q      (pend_w[i]),
        .dpend_q     (dpend_w[i]),
        .qual        (qual_w[i])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [2:0]  rd_idx;

  assign rd_idx = (cnt_sel >= 3'h1 && cnt_sel <= 3'h5)
                  ? cnt_sel - 3'h1 : 3'h0;

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      mode_rdata <= 16'h0000;
      hold_rdata <= 16'h0000;
    end else begin
      mode_rdata <= mode_q[rd_idx];
      hold_rdata <= hold_w[rd_idx];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  cmd_latch_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    cmd_wr |=> cmd_vld_q && cmd_q == $past(cmd_data))
    else $error("command not latched");

  arm_sets_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    cmd_vld_q && op == cgcd_pkg::OP_ARM && cmd_q[0] && !mreset
    |=> armed[0])
    else $error("arm did not arm counter one");

  mask_zero_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    cmd_vld_q && op == cgcd_pkg::OP_ARM && !cmd_q[0] && !armed[0]
    |=> !armed[0])
    else $error("zero mask bit changed arm state");

  retrig_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    retrig_w[0] && !mreset |=> hold_w[0] == $past(cnt_w[0]))
    else $error("retrigger did not save count");

  retrig_load_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    pend_w[0] && qual_w[0] && !mreset
    |=> cnt_w[0] == $past(load_w[0]) && !terminal_count[0])
    else $error("retrigger reload missing");

  step_retrig_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    pend_w[0] && (step_v[0] || load_v[0]) && !mreset
    |=> cnt_w[0] == $past(load_w[0]))
    else $error("command did not act as source edge");

  disarm_defer_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    disarm_v[0] && terminal_count[0] && !qual_w[0]
    && !step_v[0] && !mreset |=> dpend_w[0] && armed[0] == $past(armed[0]))
    else $error("disarm not deferred in terminal count");

  level_gate_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    mode_q[0][15:13] == cgcd_pkg::G_HIGH && !own_gate_pin[0]
    && !terminal_count[0] |-> !qual_w[0])
    else $error("counted while gated off");

  dptr_load_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    dp_ld |=> data_ptr == $past(cmd_q[4:0]))
    else $error("data pointer not loaded");

  mreset_mode_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    mreset |=> mode_q[0] == cgcd_pkg::MODE_RST && !armed[0])
    else $error("master reset left mode word");

  tog_set_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    set_v[0] && !mreset |=> counter_output_pin[0])
    else $error("toggle not set");

  retrig_cov: cover property (
    @(posedge mclk) disable iff (!rst_s_n)
    retrig_w[0] ##[1:20] qual_w[0]);

  tc_cov: cover property (
    @(posedge mclk) disable iff (!rst_s_n)
    armed[0] ##1 terminal_count[0]);

  defer_cov: cover property (
    @(posedge mclk) disable iff (!rst_s_n)
    dpend_w[0] ##[1:20] !armed[0]);
endmodule

// ===== test/cgcd_host.sv
// Host model that writes command bytes to the control port
`timescale 1ns/10ps
module cgcd_host (
  // Clock
  input  wire logic mclk,
  // Command port
  output logic       cmd_wr,
  output logic [7:0] cmd_data
);
  initial begin
    cmd_wr   = 1'b0;
    cmd_data = 8'h00;
  end
  // One whole byte per write, then wait for the effect
  task automatic send(input logic [7:0] c);
    // Unused pointer groups are never sent
    if (c[7:5] == 3'h0 && (c[2:0] == 3'h0 || c[2:0] == 3'h6)) begin
      c[0] = 1'b1;
    end
    @(posedge mclk);
    cmd_wr   <= 1'b1;
    cmd_data <= c;
    @(posedge mclk);
    cmd_wr   <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
endmodule

// ===== test/cgcd_top_bench.sv
// Self-checking bench for the gating and command decoder
`timescale 1ns/10ps
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module cgcd_top_bench;
  logic        mclk, rst_n, cmd_wr, mode_wr, load_wr;
  logic        sequencing_disable, freq_out_gate_off;
  logic        wide_bus, write_prefetch;
  logic [7:0]  cmd_data;
  logic [2:0]  cnt_sel, k;
  logic [15:0] wdata, mode_rdata, hold_rdata, v;
  logic [4:0]  freq_in, source_pin, own_gate_pin, terminal_count;
  logic [4:0]  counter_output_pin, armed, data_ptr, m, e, oh;
  logic [7:0]  mc [8];
  int          n_errors, n_tests;
  wire  [3:0]  mstat = {sequencing_disable, freq_out_gate_off,
                        wide_bus, write_prefetch};
  cgcd_host host (.mclk, .cmd_wr, .cmd_data);
  cgcd_top dut (.mclk, .rst_n, .cmd_wr, .cmd_data, .mode_wr, .load_wr,
    .cnt_sel, .wdata, .freq_in, .source_pin, .own_gate_pin,
    .terminal_count, .counter_output_pin, .armed, .mode_rdata,
    .hold_rdata, .data_ptr, .sequencing_disable, .freq_out_gate_off,
    .wide_bus, .write_prefetch);
  always #50 mclk = ~mclk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] mexp(int i);
    return i < 4 ? 4'hf << (3 - i) : 4'h7 >> (i - 4);
  endfunction
  task automatic reg_wr(input logic md, input logic [15:0] d);
    @(posedge mclk);
    mode_wr <= md;
    load_wr <= !md;
    cnt_sel <= k;
    wdata   <= d;
    @(posedge mclk);
    mode_wr <= 1'b0;
    load_wr <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic tick;
    freq_in <= 5'h01;
    repeat (3) @(posedge mclk);
    freq_in <= 5'h00;
    repeat (3) @(posedge mclk);
  endtask
  task automatic final_report;
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    {mode_wr, load_wr, cnt_sel, wdata} = '0;
    {freq_in, source_pin, own_gate_pin} = '0;
    n_errors = 0;
    n_tests = 0;
    mc = '{8'he8, 8'hee, 8'hef, 8'hf8, 8'he0, 8'he6, 8'he7, 8'hf9};
    void'($urandom(34));
    k = 3'h1;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(mode_rdata, cgcd_pkg::MODE_RST)
    `CHK(armed, 5'h00)
    for (int i = 0; i < 8; i++) begin
      host.send(mc[i]);
      `CHK(mstat, mexp(i))
    end
    for (int i = 0; i < 4; i++) begin
      e = 5'($urandom);
      host.send({3'h0, e});
      if (e[2:0] == 3'h0 || e[2:0] == 3'h6) e[0] = 1'b1;
      `CHK(data_ptr, e)
      m = 5'($urandom);
      host.send({3'h1, m});
      `CHK(armed, m)
      host.send(8'h20);
      `CHK(armed, m)
      host.send({3'h6, m});
      `CHK(armed, 5'h00)
    end
    for (int n = 1; n <= 5; n++) begin
      host.send({5'h1d, 3'(n)});
      `CHK(counter_output_pin, 5'h1f >> (5 - n))
    end
    for (int n = 1; n <= 5; n++) begin
      host.send({5'h1c, 3'(n)});
      `CHK(counter_output_pin, 5'(5'h1f << n))
    end
    for (int i = 0; i < 3; i++) begin
      k = 3'($urandom_range(5, 1));
      oh = 5'h01 << (k - 3'h1);
      v = 16'($urandom_range(65535, 4));
      reg_wr(1'b0, v);
      host.send({3'h3, oh});
      `CHK(armed, oh)
      tick;
      host.send({5'h1e, k});
      host.send({3'h5, oh});
      `CHK(hold_rdata, v - 16'h0002)
      host.send({3'h4, oh});
      `CHK(armed, 5'h00)
      reg_wr(1'b1, 16'h1800);
      `CHK(mode_rdata, 16'h1800)
    end
    // Terminal count, one-shot and repeat, deferred disarm
    k = 3'h1;
    reg_wr(1'b1, 16'h0800);
    reg_wr(1'b0, 16'h0002);
    host.send(8'h61);
    tick;
    tick;
    `CHK(terminal_count, 5'h01)
    `CHK(armed, 5'h00)
    host.send(8'ha1);
    `CHK(hold_rdata, 16'h0002)
    tick;
    `CHK(terminal_count, 5'h00)
    reg_wr(1'b1, 16'h0820);
    host.send(8'h61);
    tick;
    tick;
    `CHK(armed, 5'h01)
    host.send(8'hc1);
    `CHK(armed, 5'h01)
    tick;
    `CHK(armed, 5'h00)
    `CHK(terminal_count, 5'h00)
    // Level gating with hardware retrigger
    v = 16'($urandom_range(65535, 4));
    reg_wr(1'b1, 16'h88a0);
    reg_wr(1'b0, v);
    host.send(8'h61);
    tick;
    own_gate_pin <= 5'h01;
    repeat (3) @(posedge mclk);
    `CHK(hold_rdata, v)
    tick;
    tick;
    host.send(8'ha1);
    `CHK(hold_rdata, 16'(v - 16'h0001))
    own_gate_pin <= 5'h00;
    repeat (3) @(posedge mclk);
    own_gate_pin <= 5'h01;
    repeat (3) @(posedge mclk);
    host.send(8'hf1);
    host.send(8'ha1);
    `CHK(hold_rdata, v)
    // Neighbour gate and edge start on counter two
    k = 3'h2;
    own_gate_pin <= 5'h02;
    reg_wr(1'b1, 16'h6800);
    reg_wr(1'b0, v);
    host.send(8'h62);
    tick;
    own_gate_pin <= 5'h01;
    tick;
    host.send(8'ha2);
    `CHK(hold_rdata, 16'(v - 16'h0001))
    reg_wr(1'b1, 16'hc800);
    host.send(8'h62);
    tick;
    own_gate_pin <= 5'h03;
    repeat (2) @(posedge mclk);
    tick;
    host.send(8'ha2);
    `CHK(hold_rdata, 16'(v - 16'h0001))
    host.send(8'hff);
    `CHK(mode_rdata, cgcd_pkg::MODE_RST)
    final_report;
  end
endmodule
